// ==== aci_i2c_port.sv ====
// I2C slave port for the codec control registers, with the register file.
// Assumes SCL/SDA from a host, open-drain SDA resolved outside; power-down pin is async.
`timescale 1ns/1ps
module aci_i2c_port
(
    input wire logic core_clk,          // 100 MHz core clock
    input wire logic rst,               // Async reset, active high
    input wire logic powerDownPin_n,    // Power-down pin, active low
    input wire logic deviceAddressSelectPin, // Address-select strap
    input wire logic sclIn,             // SCL from host
    input wire logic sdaIn,             // SDA wire level
    output logic sdaOut,                // SDA output value (always 0)
    output logic sdaOe,                 // SDA pull low when high
    output logic [7:0] regFlat [0:36],  // Control register contents
    output logic busBusy                // Addressed transfer in progress
);
    typedef enum logic [5:0]
    {
        ACI_IDLE = 6'b000001,
        ACI_ADDR = 6'b000010,
        ACI_ACK = 6'b000100,
        ACI_RXB = 6'b001000,
        ACI_TXB = 6'b010000,
        ACI_MACK = 6'b100000
    } aci_state_e;

    // ==========================================================
    // Input synchronisers
    logic [2:0] sclSync_r;
    logic [2:0] sdaSync_r;
    logic [2:0] pdnSync_r;
    logic [2:0] selSync_r;
    logic sclLvl_r;
    logic sdaLvl_r;
    logic pdnLvl_r;
    logic selLvl_r;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sclSync_r <= 3'h7;
            sdaSync_r <= 3'h7;
            pdnSync_r <= 3'h0;
            selSync_r <= 3'h0;
        end
        else
        begin
            sclSync_r <= {sclSync_r[1:0], sclIn};
            sdaSync_r <= {sdaSync_r[1:0], sdaIn};
            pdnSync_r <= {pdnSync_r[1:0], powerDownPin_n};
            selSync_r <= {selSync_r[1:0], deviceAddressSelectPin};
        end
    end

    // Filtered levels update only when the last two stages agree
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sclLvl_r <= 1'b1;
            sdaLvl_r <= 1'b1;
            pdnLvl_r <= 1'b0;
            selLvl_r <= 1'b0;
        end
        else
        begin
            if (sclSync_r[1] == sclSync_r[2])
                sclLvl_r <= sclSync_r[2];
            if (sdaSync_r[1] == sdaSync_r[2])
                sdaLvl_r <= sdaSync_r[2];
            if (pdnSync_r[1] == pdnSync_r[2])
                pdnLvl_r <= pdnSync_r[2];
            if (selSync_r[1] == selSync_r[2])
                selLvl_r <= selSync_r[2];
        end
    end

    logic sclNew;
    logic sdaNew;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic pdnActive;
    assign sclNew = (sclSync_r[1] == sclSync_r[2]) ? sclSync_r[2] : sclLvl_r;
    assign sdaNew = (sdaSync_r[1] == sdaSync_r[2]) ? sdaSync_r[2] : sdaLvl_r;
    assign sclRise = sclNew & ~sclLvl_r;
    assign sclFall = ~sclNew & sclLvl_r;
    assign startSeen = sclLvl_r & sclNew & sdaLvl_r & ~sdaNew;
    assign stopSeen = sclLvl_r & sclNew & ~sdaLvl_r & sdaNew;
    assign pdnActive = ~pdnLvl_r;

    // ==========================================================
    // Protocol engine
    aci_state_e state_r;
    logic [2:0] bitCnt_r;
    logic [7:0] shift_r;
    logic isRead_r;
    logic haveRegAddr_r;
    logic [5:0] addrCnt_r;
    logic ackDrive_r;
    logic [7:0] txByte_r;

    function automatic logic [5:0] nextAddr(input logic [5:0] a);
        nextAddr = (a >= aci_pkg::ACI_LAST_REG) ? aci_pkg::ACI_CNT_RESET : a + 6'h01;
    endfunction

    function automatic logic addrMatch(input logic [6:0] a, input logic sel);
        addrMatch = (a[6:1] == aci_pkg::ACI_ADDR_FIXED) && (a[0] == sel);
    endfunction

    logic [7:0] rxByte;
    assign rxByte = {shift_r[6:0], sdaLvl_r};

    logic wrStrobe;
    logic [5:0] wrAddr;
    logic [7:0] wrData;

    // Counter beyond the last register reads as zero, never as an unknown
    logic [7:0] curReg;
    assign curReg = (addrCnt_r > aci_pkg::ACI_LAST_REG) ? 8'h00 : regFlat[addrCnt_r];

    // Eighth bit has been shifted in when the counter wrapped to zero after a rise
    logic byteDone_r;
    function automatic logic haveByte(input aci_state_e s);
        haveByte = byteDone_r && (s == ACI_ADDR || s == ACI_RXB);
    endfunction

    // Tracks that eight rises have been seen in the current byte
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            byteDone_r <= 1'b0;
        else if (startSeen || pdnActive || sclFall)
            byteDone_r <= 1'b0;
        else if (sclRise && bitCnt_r == aci_pkg::ACI_BIT_LAST && (state_r == ACI_ADDR || state_r == ACI_RXB))
            byteDone_r <= 1'b1;
    end

    // Byte engine: bits sampled on SCL rise, SDA changed after SCL fall
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= ACI_IDLE;
            bitCnt_r <= 3'h0;
            shift_r <= 8'h00;
            isRead_r <= 1'b0;
            haveRegAddr_r <= 1'b0;
            addrCnt_r <= aci_pkg::ACI_CNT_RESET;
            ackDrive_r <= 1'b0;
            txByte_r <= 8'h00;
            wrStrobe <= 1'b0;
            wrAddr <= 6'h00;
            wrData <= 8'h00;
        end
        else if (pdnActive)
        begin
            state_r <= ACI_IDLE;
            addrCnt_r <= aci_pkg::ACI_CNT_RESET;
            ackDrive_r <= 1'b0;
            wrStrobe <= 1'b0;
        end
        else
        begin
            wrStrobe <= 1'b0;
            if (startSeen)
            begin
                state_r <= ACI_ADDR;
                bitCnt_r <= 3'h0;
                ackDrive_r <= 1'b0;
            end
            else if (stopSeen)
            begin
                state_r <= ACI_IDLE;
                ackDrive_r <= 1'b0;
            end
            else
            begin
                unique case (state_r)
                    ACI_IDLE:
                    begin
                        ackDrive_r <= 1'b0;
                    end
                    ACI_ADDR, ACI_RXB:
                    begin
                        if (sclRise)
                        begin
                            shift_r <= rxByte;
                            bitCnt_r <= bitCnt_r + 3'h1;
                        end
                        // After the eighth rise, decide on the following fall
                        if (sclFall && bitCnt_r == 3'h0 && haveByte(state_r))
                        begin
                            if (state_r == ACI_ADDR)
                            begin
                                if (addrMatch(shift_r[7:1], selLvl_r))
                                begin
                                    isRead_r <= shift_r[0];
                                    haveRegAddr_r <= 1'b0;
                                    ackDrive_r <= 1'b1;
                                    state_r <= ACI_ACK;
                                end
                                else
                                    state_r <= ACI_IDLE;
                            end
                            else
                            begin
                                if (!haveRegAddr_r)
                                begin
                                    addrCnt_r <= shift_r[5:0];
                                    haveRegAddr_r <= 1'b1;
                                end
                                else
                                begin
                                    wrStrobe <= 1'b1;
                                    wrAddr <= addrCnt_r;
                                    wrData <= shift_r;
                                    addrCnt_r <= nextAddr(addrCnt_r);
                                end
                                ackDrive_r <= 1'b1;
                                state_r <= ACI_ACK;
                            end
                        end
                    end
                    ACI_ACK:
                    begin
                        // Ack held through the host's ninth pulse; on its fall released for a write, or set to data bit 7 for a read
                        if (sclFall)
                        begin
                            bitCnt_r <= 3'h0;
                            if (isRead_r)
                            begin
                                txByte_r <= curReg;
                                addrCnt_r <= nextAddr(addrCnt_r);
                                ackDrive_r <= ~curReg[7];
                                state_r <= ACI_TXB;
                            end
                            else
                            begin
                                ackDrive_r <= 1'b0;
                                state_r <= ACI_RXB;
                            end
                        end
                    end
                    ACI_TXB:
                    begin
                        if (sclFall)
                        begin
                            bitCnt_r <= bitCnt_r + 3'h1;
                            if (bitCnt_r == aci_pkg::ACI_BIT_LAST)
                            begin
                                ackDrive_r <= 1'b0; // release for host ack
                                state_r <= ACI_MACK;
                            end
                            else
                                ackDrive_r <= ~txByte_r[3'h6 - bitCnt_r];
                        end
                    end
                    ACI_MACK:
                    begin
                        if (sclRise)
                            shift_r[0] <= sdaNew;
                        if (sclFall)
                        begin
                            bitCnt_r <= 3'h0;
                            if (!shift_r[0])
                            begin
                                txByte_r <= curReg;
                                addrCnt_r <= nextAddr(addrCnt_r);
                                ackDrive_r <= ~curReg[7];
                                state_r <= ACI_TXB;
                            end
                            else
                                state_r <= ACI_IDLE;
                        end
                    end
                    default:
                        state_r <= ACI_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Register file; defaults restored while the power-down pin is low
    genvar gi;
    generate
        for (gi = 0; gi < aci_pkg::ACI_NUM_REGS; gi++)
        begin : g_reg
            localparam logic [7:0] DEF = (gi == aci_pkg::ACI_IDX_REG02) ?
                aci_pkg::ACI_DEF_REG02 : aci_pkg::ACI_DEF_OTHER;
            always_ff @(posedge core_clk or posedge rst)
            begin
                if (rst)
                    regFlat[gi] <= DEF;
                else if (pdnActive)
                    regFlat[gi] <= DEF;
                else if (wrStrobe && wrAddr == 6'(gi))
                    regFlat[gi] <= wrData;
            end
        end
    endgenerate

    // SDA and busy outputs straight from flops
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            busBusy <= 1'b0;
        end
        else
        begin
            sdaOe <= ackDrive_r & ~pdnActive; // Open drain: only ever pulls low
            sdaOut <= 1'b0;
            busBusy <= (state_r != ACI_IDLE) && (state_r != ACI_ADDR);
        end
    end

    // ==========================================================
    // Assertions
    a_silent_idle: assert property (@(posedge core_clk) disable iff (rst)
        (state_r == ACI_IDLE) |=> !sdaOe)
        else $error("SDA driven while idle");
    a_stop_release: assert property (@(posedge core_clk) disable iff (rst)
        stopSeen |=> ##1 !sdaOe)
        else $error("SDA still driven after STOP");
    a_start_addr: assert property (@(posedge core_clk) disable iff (rst || pdnActive)
        startSeen |=> state_r == ACI_ADDR)
        else $error("START not taken");
    a_pdn_counter: assert property (@(posedge core_clk) disable iff (rst)
        pdnActive |=> addrCnt_r == aci_pkg::ACI_CNT_RESET)
        else $error("Counter not cleared in power-down");
    a_pdn_defaults: assert property (@(posedge core_clk) disable iff (rst)
        pdnActive |=> regFlat[2] == aci_pkg::ACI_DEF_REG02 && regFlat[0] == 8'h00)
        else $error("Defaults not restored");
    a_wr_incr: assert property (@(posedge core_clk) disable iff (rst || pdnActive)
        wrStrobe |-> addrCnt_r == nextAddr(wrAddr))
        else $error("Counter did not advance after write");
    // Host may name an address above the map, so only the wrap itself is pinned
    a_counter_range: assert property (@(posedge core_clk) disable iff (rst || pdnActive)
        wrStrobe && wrAddr == aci_pkg::ACI_LAST_REG |-> addrCnt_r == aci_pkg::ACI_CNT_RESET)
        else $error("Counter did not wrap after last register");
    // START and STOP release the pull two cycles later, so they are exempt
    a_sda_stable: assert property (@(posedge core_clk) disable iff (rst)
        $changed(sdaOe) && !$past(pdnActive) && !$past(stopSeen, 2) && !$past(startSeen, 2) |-> !sclLvl_r)
        else $error("SDA changed while SCL high");
    a_ack_match: assert property (@(posedge core_clk) disable iff (rst || pdnActive)
        (state_r == ACI_ADDR) ##1 (state_r == ACI_ACK) |-> $past(addrMatch(shift_r[7:1], selLvl_r)))
        else $error("Ack without address match");

    c_write: cover property (@(posedge core_clk) disable iff (rst) wrStrobe);
    c_read: cover property (@(posedge core_clk) disable iff (rst) state_r == ACI_TXB);
    c_seq_read: cover property (@(posedge core_clk) disable iff (rst)
        state_r == ACI_MACK ##1 state_r == ACI_TXB);
    c_wrap: cover property (@(posedge core_clk) disable iff (rst) wrStrobe && wrAddr == aci_pkg::ACI_LAST_REG);
endmodule

// ==== aci_pkg.sv ====
// Constants shared by the audio control I2C register port.
// Assumes one 100 MHz core clock; SCL and SDA arrive asynchronously from the host.
package aci_pkg;
    localparam logic [5:0] ACI_ADDR_FIXED = 6'h09;   // 001001
    localparam logic [5:0] ACI_LAST_REG = 6'h24;
    localparam int ACI_NUM_REGS = 37;
    localparam logic [5:0] ACI_CNT_RESET = 6'h00;
    localparam logic [2:0] ACI_BIT_LAST = 3'h7;
    // Register defaults: all zero except 02H bit 0
    localparam logic [7:0] ACI_DEF_REG02 = 8'h01;
    localparam logic [5:0] ACI_IDX_REG02 = 6'h02;
    localparam logic [7:0] ACI_DEF_OTHER = 8'h00;
    localparam int ACI_SYNC_STAGES = 3;
endpackage

// ==== aci_host_model.sv ====
// Behavioural I2C host that drives the register port's SCL and SDA.
// Assumes the bench resolves SDA with a pull-up from both pull-downs.
`timescale 1ns/1ps
module aci_host_model
(
    input wire logic clk,      // Core clock, paces the bits
    input wire logic sdaWire,  // Resolved SDA level
    output logic sclOut,       // SCL from host
    output logic sdaLow        // Host pulls SDA low
);
    // ====================================
    // Bus timing
    // Idle bus: SCL stands high, SDA released
    initial
    begin
        sclOut = 1'b1;
        sdaLow = 1'b0;
    end
    task automatic waitC(input int n);
        repeat (n) @(negedge clk);
    endtask
    // START (also repeated) or STOP; SDA moves while SCL high
    task automatic lineCond(input logic isStart);
        sdaLow = ~isStart;
        waitC(6);
        sclOut = 1'b1;
        waitC(8);
        sdaLow = isStart;
        waitC(8);
        if (isStart)
        begin
            sclOut = 1'b0;
            waitC(6);
        end
    endtask
    // One 160 ns bit; long low phase lets the slow slave settle first
    task automatic bitCycle(input logic txb, output logic rxb);
        sdaLow = ~txb;
        waitC(6);
        sclOut = 1'b1;
        waitC(2);
        rxb = sdaWire;
        waitC(2);
        sclOut = 1'b0;
        waitC(6);
    endtask
    // Byte out MSB first, then SDA released for the ack
    task automatic sendByte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitCycle(d[i], r);
        bitCycle(1'b1, r);
        ack = ~r;
    endtask
    // Byte in MSB first, then ack to go on or nack to end
    task automatic recvByte(input logic giveAck, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitCycle(1'b1, r);
            d[i] = r;
        end
        bitCycle(~giveAck, r);
    endtask
endmodule

// ==== aci_i2c_port_test.sv ====
// Self-checking bench for the audio control I2C register port.
// Assumes the host model is compiled first; SDA has a pull-up here.
`timescale 1ns/1ps
module aci_i2c_port_test;
    // ====================================
    // Clock, reset, wires
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic powerDownPin_n = 1'b1;
    logic deviceAddressSelectPin = 1'b0;
    logic sclIn;
    logic sdaOut;
    logic sdaOe;
    logic busBusy;
    logic hostLow;
    logic sdaWire;
    logic prevOe = 1'b0;
    logic [7:0] regFlat [0:36];
    logic [7:0] expReg [0:36];
    logic [5:0] expCnt;
    int n_errors = 0;
    int checks_done = 0;
    int seed = 83;
    // 100 MHz core clock
    always #5 core_clk = ~core_clk;
    // Released SDA floats high through the pull-up
    assign sdaWire = ~hostLow & ~(sdaOe & ~sdaOut);
    aci_i2c_port u_aci_i2c_port
    (
        .core_clk(core_clk),
        .rst(rst),
        .powerDownPin_n(powerDownPin_n),
        .deviceAddressSelectPin(deviceAddressSelectPin),
        .sclIn(sclIn),
        .sdaIn(sdaWire),
        .sdaOut(sdaOut),
        .sdaOe(sdaOe),
        .regFlat(regFlat),
        .busBusy(busBusy)
    );
    aci_host_model u_aci_host_model
    (
        .clk(core_clk),
        .sdaWire(sdaWire),
        .sclOut(sclIn),
        .sdaLow(hostLow)
    );
    // ====================================
    // Checking helpers
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Counter steps past the last register back to zero
    function automatic logic [5:0] nextAddr(input logic [5:0] a);
        return (a == 6'h24) ? 6'h00 : a + 6'h01;
    endfunction
    task automatic setDefaults();
        foreach (expReg[i])
            expReg[i] = (i == 2) ? 8'h01 : 8'h00;
        expCnt = 6'h00;
    endtask
    task automatic checkRegs();
        foreach (regFlat[i])
            check("regFlat", regFlat[i], expReg[i]);
    endtask
    // The device may move SDA only while SCL is low; looked at once the flops have settled
    always @(posedge core_clk)
    begin
        #1;
        if (!rst && sclIn)
            check("sda held", {7'h00, sdaOe}, {7'h00, prevOe});
        prevOe = sdaOe;
    end
    // ====================================
    // Transfers
    task automatic addrPhase(input logic [7:0] a, output logic ack);
        u_aci_host_model.lineCond(1'b1);
        u_aci_host_model.sendByte(a, ack);
    endtask
    task automatic wrongAddr(input logic [7:0] a);
        logic ack;
        addrPhase(a, ack);
        check("foreign ack", {7'h00, ack}, 8'h00);
        check("foreign busy", {7'h00, busBusy}, 8'h00);
        u_aci_host_model.lineCond(1'b0);
    endtask
    // Write n random bytes from a; no STOP leaves a dummy write
    task automatic writeSeq(input logic [5:0] a, input int n, input bit doStop);
        logic ack;
        logic [7:0] d;
        addrPhase({6'b001001, deviceAddressSelectPin, 1'b0}, ack);
        check("addr ack", {7'h00, ack}, 8'h01);
        u_aci_host_model.sendByte({2'b00, a}, ack);
        check("reg ack", {7'h00, ack}, 8'h01);
        expCnt = a;
        for (int i = 0; i < n; i++)
        begin
            // Register 24H has no used bits, so it only ever gets zero
            d = (expCnt == 6'h24) ? 8'h00 : 8'($random(seed));
            u_aci_host_model.sendByte(d, ack);
            check("data ack", {7'h00, ack}, 8'h01);
            expReg[expCnt] = d;
            expCnt = nextAddr(expCnt);
        end
        if (doStop)
            u_aci_host_model.lineCond(1'b0);
    endtask
    // Read n bytes at the counter; host nacks the last, then STOP
    task automatic readSeq(input int n);
        logic ack;
        logic [7:0] d;
        addrPhase({6'b001001, deviceAddressSelectPin, 1'b1}, ack);
        check("read ack", {7'h00, ack}, 8'h01);
        check("read busy", {7'h00, busBusy}, 8'h01);
        for (int i = 0; i < n; i++)
        begin
            u_aci_host_model.recvByte(i < n - 1, d);
            check("read data", d, expReg[expCnt]);
            expCnt = nextAddr(expCnt);
        end
        u_aci_host_model.lineCond(1'b0);
        check("released", {7'h00, sdaOe}, 8'h00);
        check("idle after stop", {7'h00, busBusy}, 8'h00);
    endtask
    // ====================================
    // Main sequence
    initial
    begin
        logic [5:0] a;
        setDefaults();
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        repeat (6) @(negedge core_clk);
        checkRegs();
        readSeq(3);
        for (int s = 0; s < 2; s++)
        begin
            deviceAddressSelectPin = s[0];
            repeat (6) @(negedge core_clk);
            wrongAddr({6'b001000, s[0], 1'b0});
            wrongAddr({6'b101001, s[0], 1'b1});
            wrongAddr({6'b001001, ~s[0], 1'b0});
            writeSeq(6'h23, 4, 1'b1);
            checkRegs();
            writeSeq(6'h22, 0, 1'b0);
            readSeq(5);
            readSeq(1);
        end
        for (int k = 0; k < 12; k++)
        begin
            a = 6'($unsigned($random(seed)) % 37);
            writeSeq(a, 1 + k % 6, 1'b1);
            checkRegs();
            readSeq(1 + k % 3);
            a = 6'($unsigned($random(seed)) % 37);
            writeSeq(a, 0, 1'b0);
            readSeq(2);
        end
        powerDownPin_n = 1'b0;
        repeat (8) @(negedge core_clk);
        powerDownPin_n = 1'b1;
        repeat (6) @(negedge core_clk);
        setDefaults();
        checkRegs();
        readSeq(3);
        final_report();
    end
    // Watchdog: the run needs about a third of a millisecond
    initial
    begin
        #800000;
        n_errors++;
        final_report();
    end
endmodule
